/* rtl/err_ctl_pkg.sv */
// package: offsets, field positions, feature codes and carrier types for the error control register
package err_ctl_pkg;
   // memory-mapped placement
   localparam logic [15:0] CTL_BASE_OFFSET = 16'h0008;
   localparam logic [15:0] RECORD_STRIDE = 16'h0040;
   localparam int REG_WIDTH = 64;
   localparam int HALF_WIDTH = 32;
   // field positions
   localparam int BIT_LOG_EN = 0;
   localparam int BIT_IMPL_LOW = 1;
   localparam int BIT_RD_RECOV_UNC = 2;
   localparam int BIT_RD_FAULT = 3;
   localparam int BIT_RD_ABORT = 4;
   localparam int BIT_WR_RECOV_UNC = 5;
   localparam int BIT_WR_FAULT = 6;
   localparam int BIT_WR_ABORT = 7;
   localparam int BIT_RD_CORR_FAULT = 8;
   localparam int BIT_WR_CORR_FAULT = 9;
   localparam int BIT_RD_DEFER_RECOV = 10;
   localparam int BIT_WR_DEFER_RECOV = 11;
   localparam int BIT_CRITICAL = 13;
   localparam int IMPL_HIGH_LSB = 32;
   // reset values; undefined fields are held at zero for determinism
   localparam logic LOG_EN_RESET = 1'b0;
   localparam logic ENABLE_RESET = 1'b0;
   localparam logic [31:0] IMPL_HIGH_RESET = 32'h0000_0000;
   localparam logic IMPL_LOW_RESET = 1'b0;
   // per-control feature support
   typedef enum logic [1:0] {
      FEAT_NONE = 2'h0,
      FEAT_ALWAYS = 2'h1,
      FEAT_COMBINED = 2'h2,
      FEAT_SEPARATE = 2'h3
   } feature_t;
   // system-register access selector
   typedef enum logic [2:0] {
      SYS_LOW = 3'h1,
      SYS_HIGH = 3'h2,
      SYS_FULL = 3'h4
   } sys_sel_t;
   // an error event seen by the node's datapath
   typedef struct packed {
      logic valid;
      logic isWrite;
      logic corrected;
      logic deferred;
      logic uncorrected;
      logic critical;
      logic counterOverflow;
      logic syndromeDropped;
   } err_event_t;
   // signalling produced for an event
   typedef struct packed {
      logic faultIrq;
      logic recoveryIrq;
      logic criticalIrq;
      logic inbandAbort;
      logic record;
      logic uncontained;
   } err_signal_t;
endpackage : err_ctl_pkg

/* rtl/err_signal_gate.sv */
// combinational gating of one error event by the control register
`timescale 1ns/1ns
module err_signal_gate #(
   parameter bit HAS_COUNTERS = 1'b1,
   parameter err_ctl_pkg::feature_t CORR_FEAT = err_ctl_pkg::FEAT_SEPARATE,
   parameter err_ctl_pkg::feature_t FAULT_FEAT = err_ctl_pkg::FEAT_SEPARATE,
   parameter err_ctl_pkg::feature_t ABORT_FEAT = err_ctl_pkg::FEAT_SEPARATE,
   parameter err_ctl_pkg::feature_t UNC_FEAT = err_ctl_pkg::FEAT_SEPARATE,
   parameter err_ctl_pkg::feature_t DEFER_FEAT = err_ctl_pkg::FEAT_SEPARATE,
   parameter err_ctl_pkg::feature_t CRIT_FEAT = err_ctl_pkg::FEAT_COMBINED
) (
   // control and event
   input wire logic [63:0] ctl,
   input wire err_ctl_pkg::err_event_t evt,
   // resulting signalling
   output err_ctl_pkg::err_signal_t sig
);
   // pick the read or write enable of one control
   function automatic logic pick(input err_ctl_pkg::feature_t f, input logic [63:0] c,
                                 input int rdBit, input int wrBit, input logic isWr);
      case (f)
         err_ctl_pkg::FEAT_NONE: pick = 1'b0;
         err_ctl_pkg::FEAT_ALWAYS: pick = 1'b1;
         err_ctl_pkg::FEAT_COMBINED: pick = c[rdBit];
         err_ctl_pkg::FEAT_SEPARATE: pick = isWr ? c[wrBit] : c[rdBit];
         default: pick = 1'b0;
      endcase
   endfunction : pick

   logic active;
   logic enCorr;
   logic enFault;
   logic enAbort;
   logic enUnc;
   logic enDefer;
   logic enCrit;
   logic corrTrigger;

   always_comb begin
      active = evt.valid & ctl[err_ctl_pkg::BIT_LOG_EN];
      enCorr = pick(CORR_FEAT, ctl, err_ctl_pkg::BIT_RD_CORR_FAULT,
                    err_ctl_pkg::BIT_WR_CORR_FAULT, evt.isWrite);
      enFault = pick(FAULT_FEAT, ctl, err_ctl_pkg::BIT_RD_FAULT,
                     err_ctl_pkg::BIT_WR_FAULT, evt.isWrite);
      enAbort = pick(ABORT_FEAT, ctl, err_ctl_pkg::BIT_RD_ABORT,
                     err_ctl_pkg::BIT_WR_ABORT, evt.isWrite);
      enUnc = pick(UNC_FEAT, ctl, err_ctl_pkg::BIT_RD_RECOV_UNC,
                   err_ctl_pkg::BIT_WR_RECOV_UNC, evt.isWrite);
      enDefer = pick(DEFER_FEAT, ctl, err_ctl_pkg::BIT_RD_DEFER_RECOV,
                     err_ctl_pkg::BIT_WR_DEFER_RECOV, evt.isWrite);
      enCrit = pick(CRIT_FEAT, ctl, err_ctl_pkg::BIT_CRITICAL,
                    err_ctl_pkg::BIT_CRITICAL, evt.isWrite);
      // corrected errors count on overflow when counters exist
      corrTrigger = evt.corrected & (HAS_COUNTERS ? evt.counterOverflow : 1'b1);
      // the dropped-syndrome flag masks only the record, not the interrupts or abort
      sig.record = active & ~evt.syndromeDropped;
      sig.faultIrq = active & ((enFault & (evt.deferred | evt.uncorrected)) |
                     (enCorr & corrTrigger) |
                     ((CORR_FEAT == err_ctl_pkg::FEAT_NONE) & enFault & corrTrigger));
      sig.recoveryIrq = active & ((enDefer & evt.deferred) |
                        (enUnc & evt.uncorrected & ~evt.deferred));
      sig.inbandAbort = active & enAbort & evt.uncorrected & ~evt.deferred;
      sig.criticalIrq = active & enCrit & evt.critical;
      sig.uncontained = active & ~enCrit & evt.critical;
   end
endmodule : err_signal_gate

/* rtl/error_record_control_regs.sv */
// error record control register with memory-mapped and system-register access
//
// Contract
// - register exists only for the node's first record; other records read zero.
// - memory-mapped copy sits at eight plus 64 times record index.
// - system access reaches low half, high half, or whole selected register.
// - bits 63:32 and 1 are implementation bits; zero writes are tolerated.
// - enable bits of unimplemented features read zero and ignore writes.
// - each control is combined or split read/write, chosen at design time.
// - bit 13 enables critical interrupt; clear treats critical errors as uncontained.
// - combined bit 10 raises recovery interrupt for deferred errors.
// - split: bit 11 for writes, bit 10 for reads, deferred recovery.
// - combined bit 8 raises fault interrupt for corrected errors, on counter overflow when counters exist.
// - split: bit 9 for writes, bit 8 for reads, corrected fault.
// - combined bit 4 enables in-band abort for non-deferrable uncorrected errors.
// - split: bit 7 for writes, bit 4 for reads, in-band abort.
// - combined bit 3 raises fault interrupt for deferred and uncorrected errors.
// - split: bit 6 for writes, bit 3 for reads, fault interrupt.
// - combined bit 2 raises recovery interrupt for non-deferred uncorrected errors.
// - split: bit 5 for writes, bit 2 for reads, uncorrected recovery.
// - enabled interrupts still fire when the syndrome is dropped.
// - bit 0 clear: nothing recorded or signalled; set: logging active.
// - check codes are still generated for writes while logging is off.
// - controls reset on cold reset only, and survive error-recovery reset.
// - logging enable resets to zero; other controls then reset to defined values.
// - bits 31:14 and 12 read zero; combined-mode split bits read zero.
`timescale 1ns/1ns
module error_record_control_regs #(
   parameter int RECORD_INDEX = 0,
   parameter int SEL_WIDTH = 4,
   parameter bit FIRST_RECORD = 1'b1,
   parameter bit HAS_COUNTERS = 1'b1,
   parameter bit HAS_LOG_EN = 1'b1,
   parameter err_ctl_pkg::feature_t CORR_FEAT = err_ctl_pkg::FEAT_SEPARATE,
   parameter err_ctl_pkg::feature_t FAULT_FEAT = err_ctl_pkg::FEAT_SEPARATE,
   parameter err_ctl_pkg::feature_t ABORT_FEAT = err_ctl_pkg::FEAT_SEPARATE,
   parameter err_ctl_pkg::feature_t UNC_FEAT = err_ctl_pkg::FEAT_SEPARATE,
   parameter err_ctl_pkg::feature_t DEFER_FEAT = err_ctl_pkg::FEAT_SEPARATE,
   parameter err_ctl_pkg::feature_t CRIT_FEAT = err_ctl_pkg::FEAT_COMBINED
) (
   // clock and resets
   input wire logic clock,
   input wire logic rst_b,
   input wire logic recoveryReset,
   // memory-mapped access
   input wire logic mmioWrite,
   input wire logic mmioRead,
   input wire logic [15:0] mmioAddr,
   input wire logic [63:0] mmioWdata,
   output logic [63:0] mmioRdata,
   // system-register access
   input wire logic [SEL_WIDTH-1:0] record_select_index,
   input wire logic sysWrite,
   input wire logic sysRead,
   input wire err_ctl_pkg::sys_sel_t sysSel,
   input wire logic [63:0] sysWdata,
   output logic [63:0] sysRdata,
   // datapath events
   input wire err_ctl_pkg::err_event_t errEvent,
   // signalling out
   output err_ctl_pkg::err_signal_t errSignal,
   output logic checkCodeGen,
   input wire logic injectSuppressCheck,
   output logic [63:0] error_record_control
);
   localparam logic [15:0] MY_OFFSET = 16'(err_ctl_pkg::CTL_BASE_OFFSET +
                                        err_ctl_pkg::RECORD_STRIDE * RECORD_INDEX);
   localparam logic [SEL_WIDTH-1:0] MY_SEL = SEL_WIDTH'(RECORD_INDEX);

   // bits that hold storage for a given feature encoding
   function automatic logic [63:0] feat_mask(input err_ctl_pkg::feature_t f,
                                             input int rdBit, input int wrBit);
      feat_mask = 64'h0;
      case (f)
         err_ctl_pkg::FEAT_COMBINED: feat_mask[rdBit] = 1'b1;
         err_ctl_pkg::FEAT_SEPARATE: begin
            feat_mask[rdBit] = 1'b1;
            feat_mask[wrBit] = 1'b1;
         end
         default: feat_mask = 64'h0;
      endcase
   endfunction : feat_mask

   // writable bit mask built from the feature configuration
   localparam logic [63:0] WMASK = FIRST_RECORD ? (
      feat_mask(CORR_FEAT, err_ctl_pkg::BIT_RD_CORR_FAULT, err_ctl_pkg::BIT_WR_CORR_FAULT) |
      feat_mask(FAULT_FEAT, err_ctl_pkg::BIT_RD_FAULT, err_ctl_pkg::BIT_WR_FAULT) |
      feat_mask(ABORT_FEAT, err_ctl_pkg::BIT_RD_ABORT, err_ctl_pkg::BIT_WR_ABORT) |
      feat_mask(UNC_FEAT, err_ctl_pkg::BIT_RD_RECOV_UNC, err_ctl_pkg::BIT_WR_RECOV_UNC) |
      feat_mask(DEFER_FEAT, err_ctl_pkg::BIT_RD_DEFER_RECOV,
                err_ctl_pkg::BIT_WR_DEFER_RECOV) |
      feat_mask(CRIT_FEAT, err_ctl_pkg::BIT_CRITICAL, err_ctl_pkg::BIT_CRITICAL) |
      (HAS_LOG_EN ? (64'h1 << err_ctl_pkg::BIT_LOG_EN) : 64'h0)) : 64'h0;

   logic [63:0] ctl_q;
   logic [63:0] ctl_d;
   logic [31:0] implHigh_q;
   logic implLow_q;
   logic mmioHit;
   logic sysHit;
   logic [63:0] wrMask;
   logic [63:0] wrData;
   logic [63:0] regView;
   logic [63:0] effCtl;
   logic [63:0] mmioRdata_d;
   logic [63:0] sysRdata_d;

   // decode and merge of the two access paths; system access wins on collision
   always_comb begin
      mmioHit = FIRST_RECORD && (mmioAddr == MY_OFFSET);
      sysHit = FIRST_RECORD && (record_select_index == MY_SEL);
      wrMask = 64'h0;
      wrData = 64'h0;
      if (mmioWrite && mmioHit) begin
         wrMask = 64'hffff_ffff_ffff_ffff;
         wrData = mmioWdata;
      end
      if (sysWrite && sysHit) begin
         wrData = sysWdata;
         case (sysSel)
            err_ctl_pkg::SYS_LOW: wrMask = 64'h0000_0000_ffff_ffff;
            err_ctl_pkg::SYS_HIGH: begin
               wrMask = 64'hffff_ffff_0000_0000;
               wrData = {sysWdata[31:0], 32'h0};
            end
            err_ctl_pkg::SYS_FULL: wrMask = 64'hffff_ffff_ffff_ffff;
            default: wrMask = 64'h0;
         endcase
      end
      ctl_d = (ctl_q & ~(wrMask & WMASK)) | (wrData & wrMask & WMASK);
   end

   // cold reset only; error-recovery reset leaves the controls untouched
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         ctl_q <= {63'h0, err_ctl_pkg::LOG_EN_RESET};
      end else begin
         ctl_q <= ctl_d;
      end
   end

   // implementation bits: stored, zero writes accepted
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         implHigh_q <= err_ctl_pkg::IMPL_HIGH_RESET;
         implLow_q <= err_ctl_pkg::IMPL_LOW_RESET;
      end else if (FIRST_RECORD) begin
         if (wrMask[err_ctl_pkg::IMPL_HIGH_LSB]) begin
            implHigh_q <= wrData[63:32];
         end
         if (wrMask[err_ctl_pkg::BIT_IMPL_LOW]) begin
            implLow_q <= wrData[err_ctl_pkg::BIT_IMPL_LOW];
         end
      end
   end

   always_comb begin
      regView = ctl_q & WMASK;
      if (FIRST_RECORD) begin
         regView[63:32] = implHigh_q;
         regView[err_ctl_pkg::BIT_IMPL_LOW] = implLow_q;
      end
      // no logging-enable control means logging always on
      effCtl = ctl_q & WMASK;
      if (!HAS_LOG_EN) begin
         effCtl[err_ctl_pkg::BIT_LOG_EN] = 1'b1;
      end
      mmioRdata_d = (mmioRead && mmioHit) ? regView : 64'h0;
      sysRdata_d = 64'h0;
      if (sysRead && sysHit) begin
         case (sysSel)
            err_ctl_pkg::SYS_LOW: sysRdata_d = {32'h0, regView[31:0]};
            err_ctl_pkg::SYS_HIGH: sysRdata_d = {32'h0, regView[63:32]};
            err_ctl_pkg::SYS_FULL: sysRdata_d = regView;
            default: sysRdata_d = 64'h0;
         endcase
      end
   end

   // read data registered: valid the cycle after the read strobe
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         mmioRdata <= 64'h0;
         sysRdata <= 64'h0;
      end else begin
         mmioRdata <= mmioRdata_d;
         sysRdata <= sysRdata_d;
      end
   end

   // signalling registered one cycle after the event
   err_ctl_pkg::err_signal_t sig_d;
   err_signal_gate #(
      .HAS_COUNTERS(HAS_COUNTERS),
      .CORR_FEAT(CORR_FEAT),
      .FAULT_FEAT(FAULT_FEAT),
      .ABORT_FEAT(ABORT_FEAT),
      .UNC_FEAT(UNC_FEAT),
      .DEFER_FEAT(DEFER_FEAT),
      .CRIT_FEAT(CRIT_FEAT)
   ) gate (
      .ctl(effCtl),
      .evt(errEvent),
      .sig(sig_d)
   );

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         errSignal <= '0;
      end else if (recoveryReset) begin
         errSignal <= '0;
      end else begin
         errSignal <= sig_d;
      end
   end

   // check codes generated regardless of logging state
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         checkCodeGen <= 1'b1;
      end else begin
         checkCodeGen <= ~injectSuppressCheck;
      end
   end

   assign error_record_control = regView;
endmodule : error_record_control_regs

/* verification/error_record_control_sva.sv */
// assertion checker for the error record control register ports
`timescale 1ns/1ns
module error_record_control_sva #(
   parameter int RECORD_INDEX = 0,
   parameter bit SPLIT = 1'b1
) (
   // clock and resets
   input wire logic clock,
   input wire logic rst_b,
   input wire logic recoveryReset,
   // register access
   input wire logic mmioWrite,
   input wire logic mmioRead,
   input wire logic [15:0] mmioAddr,
   input wire logic [63:0] mmioWdata,
   input wire logic [63:0] mmioRdata,
   input wire logic sysWrite,
   // events and signalling
   input wire err_ctl_pkg::err_event_t errEvent,
   input wire err_ctl_pkg::err_signal_t errSignal,
   input wire logic checkCodeGen,
   input wire logic injectSuppressCheck,
   input wire logic [63:0] error_record_control
);
   localparam logic [15:0] ADDR = 16'h0008 + 16'(64 * RECORD_INDEX);
   // readable bits of the all-split or the all-combined layout
   localparam logic [63:0] WMASK = SPLIT ? 64'hffff_ffff_0000_2fff : 64'hffff_ffff_0000_251f;
   logic [63:0] c;
   logic hit;
   logic live;
   assign c = error_record_control;
   assign hit = mmioAddr == ADDR;
   assign live = errEvent.valid && c[0] && !recoveryReset;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);
   reserved_zero_a: assert property ({c[31:14], c[12]} == 19'h0)
      else $error("reserved control bits not zero");
   mmio_write_a: assert property (mmioWrite && hit && !sysWrite
      |=> c == ($past(mmioWdata) & WMASK)) else $error("mmio write not stored");
   mmio_miss_a: assert property (mmioWrite && !hit && !sysWrite |=> $stable(c))
      else $error("missed write changed control");
   mmio_read_a: assert property (mmioRead && hit && !mmioWrite
      |=> mmioRdata == $past(c)) else $error("mmio read data wrong");
   read_idle_a: assert property (!mmioRead |=> mmioRdata == 64'h0)
      else $error("read data without read");
   log_off_a: assert property (errEvent.valid && !c[0] |=> errSignal == '0)
      else $error("signal while logging off");
   critical_a: assert property (live && errEvent.critical
      |=> errSignal.criticalIrq == $past(c[13]) && errSignal.uncontained == !$past(c[13]))
      else $error("critical handling wrong");
   abort_split_a: assert property (live && errEvent.uncorrected && !errEvent.deferred
      |=> errSignal.inbandAbort == ((SPLIT && $past(errEvent.isWrite)) ? $past(c[7]) : $past(c[4])))
      else $error("abort enable wrong");
   record_gate_a: assert property (live
      |=> errSignal.record == !$past(errEvent.syndromeDropped)) else $error("record wrong");
   check_code_a: assert property (1'b1
      |=> checkCodeGen == !$past(injectSuppressCheck)) else $error("check code wrong");
endmodule : error_record_control_sva

bind error_record_control_regs error_record_control_sva #(.RECORD_INDEX(RECORD_INDEX),
   .SPLIT(ABORT_FEAT == err_ctl_pkg::FEAT_SEPARATE)) chk (
   .clock, .rst_b, .recoveryReset, .mmioWrite, .mmioRead, .mmioAddr, .mmioWdata, .mmioRdata,
   .sysWrite, .errEvent, .errSignal, .checkCodeGen, .injectSuppressCheck, .error_record_control);

/* verification/tb_error_record_control_regs.sv */
// self-checking bench for the error record control register
`timescale 1ns/1ns
module tb_error_record_control_regs;
   localparam logic [63:0] MASK = 64'hffff_ffff_0000_2fff;
   localparam logic [63:0] MASK2 = 64'hffff_ffff_0000_251f;
   logic clock, rst_b, recoveryReset, mmioWrite, mmioRead, sysWrite, sysRead;
   logic injectSuppressCheck, checkCodeGen;
   logic [15:0] mmioAddr;
   logic [63:0] mmioWdata, mmioRdata, sysWdata, sysRdata, ctlView, model, r;
   logic [63:0] ctlView2, model2;
   logic [3:0] recSel;
   err_ctl_pkg::sys_sel_t sysSel;
   err_ctl_pkg::err_event_t errEvent, e;
   err_ctl_pkg::err_signal_t errSignal, errSignal2;
   int numErrors = 0;
   int checksDone = 0;
   error_record_control_regs dut (.clock, .rst_b, .recoveryReset, .mmioWrite, .mmioRead,
      .mmioAddr, .mmioWdata, .mmioRdata, .record_select_index(recSel), .sysWrite, .sysRead,
      .sysSel, .sysWdata, .sysRdata, .errEvent, .errSignal, .checkCodeGen,
      .injectSuppressCheck, .error_record_control(ctlView));
   // second record: every control combined, no counters
   error_record_control_regs #(.RECORD_INDEX(1), .HAS_COUNTERS(1'b0),
      .CORR_FEAT(err_ctl_pkg::FEAT_COMBINED), .FAULT_FEAT(err_ctl_pkg::FEAT_COMBINED),
      .ABORT_FEAT(err_ctl_pkg::FEAT_COMBINED), .UNC_FEAT(err_ctl_pkg::FEAT_COMBINED),
      .DEFER_FEAT(err_ctl_pkg::FEAT_COMBINED)) dutCombined (.clock, .rst_b, .recoveryReset,
      .mmioWrite, .mmioRead, .mmioAddr, .mmioWdata, .mmioRdata(), .record_select_index(recSel),
      .sysWrite, .sysRead, .sysSel, .sysWdata, .sysRdata(), .errEvent,
      .errSignal(errSignal2), .checkCodeGen(), .injectSuppressCheck,
      .error_record_control(ctlView2));
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   task automatic giveVerdict();
      $display("checks %0d errors %0d", checksDone, numErrors);
      if (numErrors == 0 && checksDone > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : giveVerdict
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      checksDone++;
      if (seen !== exp) begin
         numErrors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic done(input string s);
      $display("test %s finished", s);
   endtask : done
   task automatic mw(input logic [15:0] a, input logic [63:0] d);
      @(posedge clock);
      mmioAddr <= a;
      mmioWdata <= d;
      mmioWrite <= 1'b1;
      @(posedge clock);
      mmioWrite <= 1'b0;
      #1;
   endtask : mw
   task automatic mr(input logic [15:0] a, input logic [63:0] exp);
      @(posedge clock);
      mmioAddr <= a;
      mmioRead <= 1'b1;
      @(posedge clock);
      mmioRead <= 1'b0;
      #1 check(mmioRdata, exp);
   endtask : mr
   task automatic sw(input err_ctl_pkg::sys_sel_t s, input logic [63:0] d, input logic [3:0] i);
      @(posedge clock);
      sysSel <= s;
      sysWdata <= d;
      recSel <= i;
      sysWrite <= 1'b1;
      @(posedge clock);
      sysWrite <= 1'b0;
      #1;
   endtask : sw
   task automatic sr(input err_ctl_pkg::sys_sel_t s, input logic [3:0] i, input logic [63:0] x);
      @(posedge clock);
      sysSel <= s;
      recSel <= i;
      sysRead <= 1'b1;
      @(posedge clock);
      sysRead <= 1'b0;
      #1 check(sysRdata, x);
   endtask : sr
   function automatic err_ctl_pkg::err_signal_t exp_sig(input logic [63:0] c,
      input err_ctl_pkg::err_event_t v, input bit split);
      err_ctl_pkg::err_signal_t s;
      logic w;
      s = '0;
      // combined controls ignore direction; the combined record has no counters
      w = v.isWrite && split;
      if (v.valid && c[0]) begin
         s.faultIrq = (v.corrected && (v.counterOverflow || !split) && c[w ? 9 : 8]) ||
            ((v.deferred || v.uncorrected) && c[w ? 6 : 3]);
         s.recoveryIrq = (v.deferred && c[w ? 11 : 10]) ||
            (v.uncorrected && !v.deferred && c[w ? 5 : 2]);
         s.criticalIrq = v.critical && c[13];
         s.uncontained = v.critical && !c[13];
         s.inbandAbort = v.uncorrected && !v.deferred && c[w ? 7 : 4];
         s.record = !v.syndromeDropped;
      end
      return s;
   endfunction : exp_sig
   task automatic ev(input err_ctl_pkg::err_event_t v);
      @(posedge clock);
      errEvent <= v;
      @(posedge clock);
      errEvent <= '0;
      #1 check(64'(errSignal), 64'(exp_sig(model, v, 1'b1)));
      check(64'(errSignal2),
         64'(exp_sig(model2, v, 1'b0)));
   endtask : ev
   initial begin
      repeat (20000) @(posedge clock);
      numErrors++;
      giveVerdict();
   end
   initial begin
      {rst_b, recoveryReset, mmioWrite, mmioRead, sysWrite, sysRead} = 6'h00;
      {injectSuppressCheck, mmioAddr, mmioWdata, sysWdata, recSel} = '0;
      sysSel = err_ctl_pkg::SYS_LOW;
      errEvent = '0;
      void'($urandom(32'hcfd6));
      repeat (15) @(posedge clock);
      #1 check(64'(checkCodeGen), 64'h1);
      check(ctlView, 64'h0);
      @(posedge clock);
      rst_b <= 1'b1;
      mr(16'h0008, 64'h0);
      mw(16'h0008, '1);
      check(ctlView, MASK);
      mr(16'h0008, MASK);
      mw(16'h0048, 64'h0);
      mw(16'h0010, 64'h0);
      check(ctlView, MASK);
      mr(16'h0048, 64'h0);
      done("mmio");
      sw(err_ctl_pkg::SYS_LOW, 64'h0, 4'h0);
      check(ctlView, 64'hffff_ffff_0000_0000);
      sw(err_ctl_pkg::SYS_HIGH, 64'h1234_5678, 4'h0);
      sr(err_ctl_pkg::SYS_HIGH, 4'h0, 64'h1234_5678);
      sw(err_ctl_pkg::SYS_FULL, 64'h0000_00a5_0000_2aa5, 4'h0);
      sr(err_ctl_pkg::SYS_LOW, 4'h0, 64'h2aa5);
      sw(err_ctl_pkg::SYS_FULL, 64'h0, 4'h3);
      sr(err_ctl_pkg::SYS_FULL, 4'h3, 64'h0);
      sr(err_ctl_pkg::SYS_FULL, 4'h0, 64'h0000_00a5_0000_2aa5);
      model = 64'h0000_00a5_0000_2aa5;
      @(posedge clock);
      recoveryReset <= 1'b1;
      @(posedge clock);
      recoveryReset <= 1'b0;
      #1 check(ctlView, model);
      done("system");
      for (int i = 0; i < 60; i++) begin
         r = {$urandom, $urandom};
         r[0] = (i % 5 != 4);
         model = r & MASK;
         mw(16'h0008, r);
         check(ctlView, model);
         mw(16'h0048, r);
         model2 = r & MASK2;
         check(ctlView2, model2);
         repeat (4) begin
            e = 8'($urandom);
            e.valid = 1'b1;
            if (e.deferred) e.uncorrected = 1'b0;
            if (!(e.corrected || e.deferred || e.uncorrected || e.critical)) e.corrected = 1'b1;
            ev(e);
         end
      end
      done("events");
      mw(16'h0008, 64'h0);
      model = 64'h0;
      ev(8'hff);
      @(posedge clock);
      injectSuppressCheck <= 1'b1;
      @(posedge clock);
      injectSuppressCheck <= 1'b0;
      #1 check(64'(checkCodeGen), 64'h0);
      @(posedge clock);
      #1 check(64'(checkCodeGen), 64'h1);
      mw(16'h0008, '1);
      @(posedge clock);
      rst_b <= 1'b0;
      @(posedge clock);
      #1 check(ctlView, 64'h0);
      @(posedge clock);
      rst_b <= 1'b1;
      mr(16'h0008, 64'h0);
      done("reset");
      giveVerdict();
   end
endmodule : tb_error_record_control_regs
